// ==== logic/exc_pkg.sv ====
/*
 * Constants, cause indices, vector numbers and state codes shared by the
 * exception sequencing unit and its helper modules.
 * Assumes a single clock domain and a 16-bit processor status word.
 */
`default_nettype none

package exc_pkg;

    // ------------------------------------------------------------------
    // Vector numbers and vector table geometry.
    // ------------------------------------------------------------------
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_BUS_ERR = 8'h02;
    localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL = 8'h04;
    localparam logic [7:0] VEC_DIV_ZERO = 8'h05;
    localparam logic [7:0] VEC_BOUNDS = 8'h06;
    localparam logic [7:0] VEC_OVERFLOW = 8'h07;
    localparam logic [7:0] VEC_PRIV = 8'h08;
    localparam logic [7:0] VEC_TRACE = 8'h09;
    localparam logic [7:0] VEC_LINE_A = 8'h0A;
    localparam logic [7:0] VEC_LINE_F = 8'h0B;
    localparam logic [7:0] VEC_UNINIT = 8'h0F;
    localparam logic [7:0] VEC_SPURIOUS = 8'h18;
    localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
    localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
    localparam logic [7:0] VEC_USER_FIRST = 8'h40;
    localparam logic [31:0] TABLE_BASE = 32'h0000_0000;
    localparam logic [31:0] TABLE_LAST = 32'h0000_03FF;
    localparam int VEC_SHIFT = 2;
    localparam logic [2:0] WORDS_NORMAL = 3'h2;
    localparam logic [2:0] WORDS_RESET = 3'h4;
    localparam logic SPACE_DATA = 1'h0;
    localparam logic SPACE_PROGRAM = 1'h1;

    // ------------------------------------------------------------------
    // Cause indices; a lower index has the higher priority.
    // ------------------------------------------------------------------
    localparam int CAUSES = 13;
    localparam logic [3:0] C_RESET = 4'h0;
    localparam logic [3:0] C_ADDR_ERR = 4'h1;
    localparam logic [3:0] C_BUS_ERR = 4'h2;
    localparam logic [3:0] C_TRACE = 4'h3;
    localparam logic [3:0] C_IRQ = 4'h4;
    localparam logic [3:0] C_ILLEGAL = 4'h5;
    localparam logic [3:0] C_PRIV = 4'h6;
    localparam logic [3:0] C_LINE_A = 4'h7;
    localparam logic [3:0] C_LINE_F = 4'h8;
    localparam logic [3:0] C_TRAP = 4'h9;
    localparam logic [3:0] C_OVERFLOW = 4'hA;
    localparam logic [3:0] C_BOUNDS = 4'hB;
    localparam logic [3:0] C_DIV_ZERO = 4'hC;
    localparam int GROUP0_LAST = 2;
    localparam int GROUP2_FIRST = 9;

    // ------------------------------------------------------------------
    // Processor status word layout and sequencer state codes.
    // ------------------------------------------------------------------
    localparam int SR_T_BIT = 15;
    localparam int SR_S_BIT = 13;
    localparam int SR_MASK_LO = 8;
    localparam logic [15:0] SR_RESET_VALUE = 16'h2700;
    localparam logic [2:0] MASK_MAX = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ENTER = 3'b001,
        ST_IACK = 3'b010,
        ST_SAVE = 3'b011,
        ST_FETCH = 3'b100,
        ST_CHAIN = 3'b101
    } state_e;

endpackage : exc_pkg

`default_nettype wire

// ==== logic/exception_vector_priority_unit.sv ====
/*
 * Exception sequencing unit of the processor core: collects exception
 * causes, arbitrates them, runs the status, vector, save and fetch phases.
 * Assumes the core hands it events synchronous to MCLK, performs the bus
 * cycles it requests, and waits at an instruction boundary while busy.
 */
`default_nettype none

module exception_vector_priority_unit (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic RESET_REQ,
    input wire logic BUS_IDLE,
    input wire logic BUS_ERROR,
    input wire logic ACCESS_VALID,
    input wire logic ACCESS_WORD,
    input wire logic ACCESS_ADDR0,
    input wire logic INSTR_BOUNDARY,
    input wire logic NEXT_ILLEGAL,
    input wire logic NEXT_PRIV,
    input wire logic NEXT_LINE_A,
    input wire logic NEXT_LINE_F,
    input wire logic TRAP_EXEC,
    input wire logic [3:0] TRAP_NUM,
    input wire logic OVERFLOW_EXEC,
    input wire logic BOUNDS_EXEC,
    input wire logic DIV_ZERO_EXEC,
    input wire logic [2:0] IRQ_LEVEL,
    input wire logic IACK_DONE,
    input wire logic IACK_BUS_ERROR,
    input wire logic AUTOVECTOR_REQUEST_N,
    input wire logic [15:0] IACK_DATA,
    input wire logic STACK_DONE,
    input wire logic VEC_FETCH_DONE,
    input wire logic SR_WRITE,
    input wire logic [15:0] SR_WDATA,
    output logic [15:0] PROCESSOR_STATUS_WORD,
    output logic [15:0] SAVED_STATUS_WORD,
    output logic EXC_ACTIVE,
    output logic ABORT_INSTR,
    output logic IACK_REQ,
    output logic [2:0] IACK_LEVEL,
    output logic STACK_REQ,
    output logic STACK_LONG_FRAME,
    output logic VEC_FETCH_REQ,
    output logic [31:0] VEC_ADDR,
    output logic VEC_PROGRAM_SPACE,
    output logic [2:0] VEC_WORDS,
    output logic [7:0] VECTOR_NUMBER,
    output logic RESUME
);

    // ------------------------------------------------------------------
    // State record.
    // ------------------------------------------------------------------
    typedef struct packed {
        exc_pkg::state_e st;
        logic [12:0] pend;
        logic [3:0] cause;
        logic [7:0] vec;
        logic [3:0] trap_num;
        logic [2:0] level;
        logic [15:0] sr;
        logic [15:0] saved_sr;
        logic abort;
        logic iack_req;
        logic stack_req;
        logic stack_long;
        logic fetch_req;
        logic [31:0] vaddr;
        logic space;
        logic [2:0] words;
        logic resume;
    } unit_s;

    unit_s s_q;
    unit_s s_d;

    logic [12:0] pend_now;
    logic [12:0] eligible;
    logic irq_ok;
    logic at_start;
    logic sel_valid;
    logic [3:0] sel_cause;
    logic [7:0] sel_vec;
    logic [31:0] addr_of_vec;
    logic [2:0] cur_mask;

    vector_cause_select u_select (
        .eligible(eligible),
        .trap_num(TRAP_EXEC ? TRAP_NUM : s_q.trap_num),
        .valid(sel_valid),
        .cause(sel_cause),
        .vec_num(sel_vec)
    );

    vector_address_former u_former (
        .vec_num(s_q.vec),
        .vec_addr(addr_of_vec)
    );

    // ------------------------------------------------------------------
    // Cause collection and eligibility.
    // ------------------------------------------------------------------
    always_comb begin
        cur_mask = s_q.sr[exc_pkg::SR_MASK_LO +: 3];
        pend_now = s_q.pend;
        if (ACCESS_VALID && ACCESS_WORD && ACCESS_ADDR0) begin
            pend_now[exc_pkg::C_ADDR_ERR] = 1'b1;
        end
        if (BUS_ERROR) begin
            pend_now[exc_pkg::C_BUS_ERR] = 1'b1;
        end
        if (TRAP_EXEC) begin
            pend_now[exc_pkg::C_TRAP] = 1'b1;
        end
        if (OVERFLOW_EXEC) begin
            pend_now[exc_pkg::C_OVERFLOW] = 1'b1;
        end
        if (BOUNDS_EXEC) begin
            pend_now[exc_pkg::C_BOUNDS] = 1'b1;
        end
        if (DIV_ZERO_EXEC) begin
            pend_now[exc_pkg::C_DIV_ZERO] = 1'b1;
        end
        if (INSTR_BOUNDARY) begin
            pend_now[exc_pkg::C_TRACE] = pend_now[exc_pkg::C_TRACE]
                | s_q.sr[exc_pkg::SR_T_BIT];
            pend_now[exc_pkg::C_ILLEGAL] = pend_now[exc_pkg::C_ILLEGAL]
                | NEXT_ILLEGAL;
            pend_now[exc_pkg::C_PRIV] = pend_now[exc_pkg::C_PRIV]
                | NEXT_PRIV;
            pend_now[exc_pkg::C_LINE_A] = pend_now[exc_pkg::C_LINE_A]
                | NEXT_LINE_A;
            pend_now[exc_pkg::C_LINE_F] = pend_now[exc_pkg::C_LINE_F]
                | NEXT_LINE_F;
        end
        if (pend_now[exc_pkg::C_ADDR_ERR] || pend_now[exc_pkg::C_BUS_ERR]) begin
            pend_now[12:exc_pkg::GROUP2_FIRST] = '0;
        end
        pend_now[exc_pkg::C_IRQ] = 1'b0;
        irq_ok = (IRQ_LEVEL != 3'h0)
            && ((IRQ_LEVEL == exc_pkg::MASK_MAX) || (IRQ_LEVEL > cur_mask));
        at_start = (s_q.st == exc_pkg::ST_IDLE) || (s_q.st == exc_pkg::ST_CHAIN);
        eligible = '0;
        if (|pend_now[exc_pkg::GROUP0_LAST:0]) begin
            if (BUS_IDLE && at_start) begin
                eligible[exc_pkg::GROUP0_LAST:0] =
                    pend_now[exc_pkg::GROUP0_LAST:0];
            end
        end else if ((INSTR_BOUNDARY && s_q.st == exc_pkg::ST_IDLE)
                     || s_q.st == exc_pkg::ST_CHAIN) begin
            eligible = pend_now;
            eligible[exc_pkg::C_IRQ] = irq_ok;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.pend = pend_now;
        s_d.abort = 1'b0;
        s_d.resume = 1'b0;
        if (TRAP_EXEC) begin
            s_d.trap_num = TRAP_NUM;
        end
        if (SR_WRITE && s_q.st == exc_pkg::ST_IDLE) begin
            s_d.sr = SR_WDATA;
        end
        case (s_q.st)
            exc_pkg::ST_IDLE, exc_pkg::ST_CHAIN: begin
                if (sel_valid) begin
                    s_d.st = exc_pkg::ST_ENTER;
                    s_d.cause = sel_cause;
                    s_d.vec = sel_vec;
                    s_d.level = IRQ_LEVEL;
                    s_d.pend[sel_cause] = 1'b0;
                    s_d.abort = (sel_cause <= 4'(exc_pkg::GROUP0_LAST));
                end else if (s_q.st == exc_pkg::ST_CHAIN) begin
                    s_d.st = exc_pkg::ST_IDLE;
                    s_d.resume = 1'b1;
                end
            end
            exc_pkg::ST_ENTER: begin
                s_d.saved_sr = s_q.sr;
                s_d.sr[exc_pkg::SR_S_BIT] = 1'b1;
                s_d.sr[exc_pkg::SR_T_BIT] = 1'b0;
                if (s_q.cause == exc_pkg::C_RESET) begin
                    s_d.sr[exc_pkg::SR_MASK_LO +: 3] = exc_pkg::MASK_MAX;
                    s_d.st = exc_pkg::ST_FETCH;
                    s_d.fetch_req = 1'b1;
                    s_d.vaddr = addr_of_vec;
                    s_d.space = exc_pkg::SPACE_PROGRAM;
                    s_d.words = exc_pkg::WORDS_RESET;
                end else if (s_q.cause == exc_pkg::C_IRQ) begin
                    s_d.sr[exc_pkg::SR_MASK_LO +: 3] = s_q.level;
                    s_d.st = exc_pkg::ST_IACK;
                    s_d.iack_req = 1'b1;
                end else begin
                    s_d.st = exc_pkg::ST_SAVE;
                    s_d.stack_req = 1'b1;
                    s_d.stack_long = (s_q.cause == exc_pkg::C_ADDR_ERR)
                        || (s_q.cause == exc_pkg::C_BUS_ERR);
                end
            end
            exc_pkg::ST_IACK: begin
                if (IACK_DONE) begin
                    s_d.iack_req = 1'b0;
                    if (IACK_BUS_ERROR) begin
                        s_d.vec = exc_pkg::VEC_SPURIOUS;
                    end else if (!AUTOVECTOR_REQUEST_N) begin
                        s_d.vec = exc_pkg::VEC_AUTO_BASE
                            + {5'h00, s_q.level};
                    end else begin
                        s_d.vec = IACK_DATA[7:0];
                    end
                    s_d.st = exc_pkg::ST_SAVE;
                    s_d.stack_req = 1'b1;
                    s_d.stack_long = 1'b0;
                end
            end
            exc_pkg::ST_SAVE: begin
                if (STACK_DONE) begin
                    s_d.stack_req = 1'b0;
                    s_d.st = exc_pkg::ST_FETCH;
                    s_d.fetch_req = 1'b1;
                    s_d.vaddr = addr_of_vec;
                    s_d.space = exc_pkg::SPACE_DATA;
                    s_d.words = exc_pkg::WORDS_NORMAL;
                end
            end
            exc_pkg::ST_FETCH: begin
                if (VEC_FETCH_DONE) begin
                    s_d.fetch_req = 1'b0;
                    s_d.st = exc_pkg::ST_CHAIN;
                end
            end
            default: begin
                s_d.st = exc_pkg::ST_IDLE;
            end
        endcase
        if (RESET_REQ) begin
            s_d.st = exc_pkg::ST_IDLE;
            s_d.pend = '0;
            s_d.pend[exc_pkg::C_RESET] = 1'b1;
            s_d.iack_req = 1'b0;
            s_d.stack_req = 1'b0;
            s_d.fetch_req = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_q <= '{st: exc_pkg::ST_IDLE, sr: exc_pkg::SR_RESET_VALUE,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    always_comb begin
        PROCESSOR_STATUS_WORD = s_q.sr;
        SAVED_STATUS_WORD = s_q.saved_sr;
        EXC_ACTIVE = (s_q.st != exc_pkg::ST_IDLE);
        ABORT_INSTR = s_q.abort;
        IACK_REQ = s_q.iack_req;
        IACK_LEVEL = s_q.level;
        STACK_REQ = s_q.stack_req;
        STACK_LONG_FRAME = s_q.stack_long;
        VEC_FETCH_REQ = s_q.fetch_req;
        VEC_ADDR = s_q.vaddr;
        VEC_PROGRAM_SPACE = s_q.space;
        VEC_WORDS = s_q.words;
        VECTOR_NUMBER = s_q.vec;
        RESUME = s_q.resume;
    end

endmodule : exception_vector_priority_unit

`default_nettype wire

// ==== logic/vector_address_former.sv ====
/*
 * Forms the 32-bit vector table address of an 8-bit vector number.
 * Assumes the table begins at address zero.
 */
`default_nettype none

module vector_address_former (
    input wire logic [7:0] vec_num,
    output logic [31:0] vec_addr
);

    // ------------------------------------------------------------------
    // Shift left by two, zero-fill the upper bits.
    // ------------------------------------------------------------------
    always_comb begin
        vec_addr = exc_pkg::TABLE_BASE | ({24'h000000, vec_num} << exc_pkg::VEC_SHIFT);
    end

endmodule : vector_address_former

`default_nettype wire

// ==== logic/vector_cause_select.sv ====
/*
 * Picks the highest priority eligible cause and its internal vector number.
 * Assumes the caller has already masked the causes that may not start yet.
 */
`default_nettype none

module vector_cause_select (
    input wire logic [12:0] eligible,
    input wire logic [3:0] trap_num,
    output logic valid,
    output logic [3:0] cause,
    output logic [7:0] vec_num
);

    // ------------------------------------------------------------------
    // Priority pick and fixed vector numbers.
    // ------------------------------------------------------------------
    function automatic logic [3:0] first_set(input logic [12:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = exc_pkg::CAUSES - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : first_set

    function automatic logic [7:0] cause_vector(input logic [3:0] c,
                                               input logic [3:0] n);
        logic [7:0] r;
        case (c)
            exc_pkg::C_RESET: r = exc_pkg::VEC_RESET;
            exc_pkg::C_ADDR_ERR: r = exc_pkg::VEC_ADDR_ERR;
            exc_pkg::C_BUS_ERR: r = exc_pkg::VEC_BUS_ERR;
            exc_pkg::C_TRACE: r = exc_pkg::VEC_TRACE;
            exc_pkg::C_ILLEGAL: r = exc_pkg::VEC_ILLEGAL;
            exc_pkg::C_PRIV: r = exc_pkg::VEC_PRIV;
            exc_pkg::C_LINE_A: r = exc_pkg::VEC_LINE_A;
            exc_pkg::C_LINE_F: r = exc_pkg::VEC_LINE_F;
            exc_pkg::C_TRAP: r = exc_pkg::VEC_TRAP_BASE + {4'h0, n};
            exc_pkg::C_OVERFLOW: r = exc_pkg::VEC_OVERFLOW;
            exc_pkg::C_BOUNDS: r = exc_pkg::VEC_BOUNDS;
            exc_pkg::C_DIV_ZERO: r = exc_pkg::VEC_DIV_ZERO;
            default: r = exc_pkg::VEC_UNINIT;
        endcase
        return r;
    endfunction : cause_vector

    always_comb begin
        valid = |eligible;
        cause = first_set(eligible);
        vec_num = cause_vector(cause, trap_num);
    end

endmodule : vector_cause_select

`default_nettype wire

// ==== sim/exc_props.sv ====
/*
 * Checker for the exception unit: vector forming, entry, acknowledge.
 * Assumes only the top module ports; bound to every unit instance.
 */
`default_nettype none

module exc_props (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic RESET_REQ,
    input wire logic BUS_IDLE,
    input wire logic BUS_ERROR,
    input wire logic ACCESS_VALID,
    input wire logic ACCESS_WORD,
    input wire logic ACCESS_ADDR0,
    input wire logic INSTR_BOUNDARY,
    input wire logic IACK_DONE,
    input wire logic IACK_BUS_ERROR,
    input wire logic AUTOVECTOR_REQUEST_N,
    input wire logic [15:0] IACK_DATA,
    input wire logic [15:0] PROCESSOR_STATUS_WORD,
    input wire logic EXC_ACTIVE,
    input wire logic ABORT_INSTR,
    input wire logic IACK_REQ,
    input wire logic [2:0] IACK_LEVEL,
    input wire logic STACK_REQ,
    input wire logic STACK_LONG_FRAME,
    input wire logic VEC_FETCH_REQ,
    input wire logic [31:0] VEC_ADDR,
    input wire logic VEC_PROGRAM_SPACE,
    input wire logic [2:0] VEC_WORDS,
    input wire logic [7:0] VECTOR_NUMBER,
    input wire logic RESUME
);
    // ----------------------------------------------------------------
    // Helper logic.
    // ----------------------------------------------------------------
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    logic [7:0] byte_q;
    logic ack;
    logic odd;
    assign ack = IACK_REQ && IACK_DONE;
    assign odd = ACCESS_VALID && ACCESS_WORD && ACCESS_ADDR0;
    always_ff @(posedge MCLK) byte_q <= IACK_DATA[7:0];

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    a_vec_addr_form: assert property (
        VEC_FETCH_REQ |-> VEC_ADDR == {22'h0, VECTOR_NUMBER, 2'h0})
        else $error("vector address wrong");
    a_fetch_kind: assert property (
        VEC_FETCH_REQ |-> (VECTOR_NUMBER == 8'h0) ?
        (VEC_WORDS == 3'h4 && VEC_PROGRAM_SPACE) :
        (VEC_WORDS == 3'h2 && !VEC_PROGRAM_SPACE))
        else $error("vector fetch size or space wrong");
    a_group0_start: assert property (
        (RESET_REQ || BUS_ERROR || odd) && BUS_IDLE && !EXC_ACTIVE
        |-> ##[1:2] ABORT_INSTR)
        else $error("group 0 start late");
    a_entry_state: assert property (
        $rose(EXC_ACTIVE) |=> PROCESSOR_STATUS_WORD[13] &&
        !PROCESSOR_STATUS_WORD[15])
        else $error("entry status wrong");
    a_trace_take: assert property (
        INSTR_BOUNDARY && PROCESSOR_STATUS_WORD[15] && !EXC_ACTIVE &&
        !BUS_ERROR && !RESET_REQ && !ACCESS_VALID
        |=> EXC_ACTIVE && VECTOR_NUMBER == 8'h09)
        else $error("trace not taken");
    a_auto_vector: assert property (
        ack && !IACK_BUS_ERROR && !AUTOVECTOR_REQUEST_N
        |=> VECTOR_NUMBER == 8'h18 + {5'h0, $past(IACK_LEVEL)})
        else $error("autovector wrong");
    a_spurious_vec: assert property (
        ack && IACK_BUS_ERROR |=> VECTOR_NUMBER == 8'h18)
        else $error("spurious vector wrong");
    a_peri_vector: assert property (
        ack && !IACK_BUS_ERROR && AUTOVECTOR_REQUEST_N
        |=> VECTOR_NUMBER == byte_q)
        else $error("supplied vector wrong");
    a_iack_mask: assert property (
        IACK_REQ |-> PROCESSOR_STATUS_WORD[10:8] == IACK_LEVEL)
        else $error("mask not updated");
    a_iack_stack: assert property (
        ack |=> STACK_REQ && !IACK_REQ)
        else $error("save not after acknowledge");
    a_short_frame: assert property (
        ack |=> !STACK_LONG_FRAME)
        else $error("interrupt frame not short");
    a_resume_end: assert property (
        RESUME |-> !EXC_ACTIVE ##1 !RESUME)
        else $error("resume pulse wrong");
    c_autovec: cover property (ack && !AUTOVECTOR_REQUEST_N);
    c_reset_fetch: cover property (VEC_FETCH_REQ && VEC_PROGRAM_SPACE);
    c_resume: cover property (RESUME);
endmodule : exc_props

bind exception_vector_priority_unit exc_props props_u (.*);

`default_nettype wire

// ==== sim/exception_vector_priority_unit_tb_top.sv ====
/*
 * Testbench of the exception unit: vectors, priorities, chaining.
 * Assumes the partner model answers every bus request.
 */
`default_nettype none

module exception_vector_priority_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Signals.
    // ----------------------------------------------------------------
    localparam logic [14:0] E_BERR = 15'h1, E_ODD = 15'hE, E_IB = 15'h10;
    localparam logic [14:0] E_ILL = 15'h20, E_TRP = 15'h200;
    localparam logic [14:0] E_RST = 15'h2000, E_SRW = 15'h4000;
    localparam logic [14:0] TE [10] = '{15'h30, 15'h50, 15'h90, 15'h110,
        15'h410, 15'h810, 15'h1010, 15'h1, 15'hE, 15'h210};
    localparam logic [7:0] TV [10] = '{8'h04, 8'h08, 8'h0A, 8'h0B,
        8'h07, 8'h06, 8'h05, 8'h02, 8'h03, 8'h25};
    logic MCLK = 1'h0, RST = 1'h1, BUS_IDLE = 1'h1;
    logic [14:0] ev = 15'h0;
    logic RESET_REQ, BUS_ERROR, ACCESS_VALID, ACCESS_WORD, ACCESS_ADDR0;
    logic INSTR_BOUNDARY, NEXT_ILLEGAL, NEXT_PRIV, NEXT_LINE_A;
    logic NEXT_LINE_F, TRAP_EXEC, OVERFLOW_EXEC, BOUNDS_EXEC;
    logic DIV_ZERO_EXEC, SR_WRITE, avec = 1'h0, berr = 1'h0;
    logic [3:0] TRAP_NUM = 4'h0, lat = 4'h0;
    logic [2:0] IRQ_LEVEL = 3'h0, IACK_LEVEL, VEC_WORDS;
    logic [15:0] SR_WDATA = 16'h0, IACK_DATA;
    logic [15:0] PROCESSOR_STATUS_WORD, SAVED_STATUS_WORD;
    logic [7:0] vbyte = 8'h40, VECTOR_NUMBER;
    logic IACK_DONE, IACK_BUS_ERROR, AUTOVECTOR_REQUEST_N, STACK_DONE;
    logic VEC_FETCH_DONE, EXC_ACTIVE, ABORT_INSTR, IACK_REQ, STACK_REQ;
    logic STACK_LONG_FRAME, VEC_FETCH_REQ, VEC_PROGRAM_SPACE, RESUME;
    logic [31:0] VEC_ADDR;
    logic [7:0] seen [$];
    logic fq = 1'h0;
    int error_cnt = 0;
    int tests_run = 0;
    assign {SR_WRITE, RESET_REQ, DIV_ZERO_EXEC, BOUNDS_EXEC, OVERFLOW_EXEC,
        TRAP_EXEC, NEXT_LINE_F, NEXT_LINE_A, NEXT_PRIV, NEXT_ILLEGAL,
        INSTR_BOUNDARY, ACCESS_ADDR0, ACCESS_WORD, ACCESS_VALID,
        BUS_ERROR} = ev;

    exception_vector_priority_unit dut_u (.*);
    vec_partner mem_u (.clk(MCLK), .rst(RST),
        .req({VEC_FETCH_REQ, STACK_REQ, IACK_REQ}), .lat(lat),
        .avec(avec), .berr(berr), .vbyte(vbyte),
        .done({VEC_FETCH_DONE, STACK_DONE, IACK_DONE}),
        .bus_err(IACK_BUS_ERROR), .avec_n(AUTOVECTOR_REQUEST_N),
        .data(IACK_DATA));

    always #20 MCLK = ~MCLK;
    always @(negedge MCLK) begin
        fq <= VEC_FETCH_REQ;
        if (VEC_FETCH_REQ && !fq) begin
            seen.push_back(VECTOR_NUMBER);
        end
        if (IACK_REQ) begin
            IRQ_LEVEL <= 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // Tasks.
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp=%h got=%h", nm, exp, got);
        end
    endtask : chk

    task fire(input logic [14:0] e);
        ev = e;
        @(posedge MCLK);
        #1;
        ev = 15'h0;
    endtask : fire

    task srw(input logic [15:0] v);
        SR_WDATA = v;
        fire(E_SRW);
    endtask : srw

    task go(input logic [14:0] e, input int n, input logic [7:0] v0, v1);
        int k;
        seen.delete();
        fire(e);
        k = 0;
        while (RESUME !== 1'h1 && k < 300) begin
            @(negedge MCLK);
            k++;
        end
        chk("resume", {31'h0, RESUME}, 32'h1);
        chk("count", seen.size(), n);
        chk("first", seen[0], v0);
        if (n > 1) chk("second", seen[1], v1);
        repeat (2) @(posedge MCLK);
        #1;
    endtask : go

    task irq(input logic [2:0] lv, input logic a, b, input logic [7:0] v, x);
        srw(16'h0000);
        IRQ_LEVEL = lv;
        avec = a;
        berr = b;
        vbyte = v;
        lat = lat + 4'h3;
        go(E_IB, 1, x, 8'h00);
    endtask : irq

    task final_report;
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge MCLK);
        #1;
        RST = 1'h0;
        @(posedge MCLK);
        #1;
        srw(16'h0000);
        go(E_RST, 1, 8'h00, 8'h00);
        chk("status", PROCESSOR_STATUS_WORD, 16'h2700);
        TRAP_NUM = 4'h5;
        for (int i = 0; i < 10; i++) begin
            go(TE[i], 1, TV[i], 8'h00);
        end
        go(E_ODD | E_BERR, 2, 8'h03, 8'h02);
        go(E_RST | E_BERR, 1, 8'h00, 8'h00);
        go(E_BERR | E_TRP | E_IB, 1, 8'h02, 8'h00);
        irq(3'h1, 1'h1, 1'h0, 8'h40, 8'h19);
        irq(3'h7, 1'h1, 1'h0, 8'h40, 8'h1F);
        irq(3'h2, 1'h0, 1'h0, 8'h40, 8'h40);
        irq(3'h2, 1'h0, 1'h0, 8'hFF, 8'hFF);
        irq(3'h2, 1'h0, 1'h0, 8'h0F, 8'h0F);
        irq(3'h4, 1'h0, 1'h1, 8'h40, 8'h18);
        srw(16'h0000);
        IRQ_LEVEL = 3'h2;
        avec = 1'h1;
        berr = 1'h0;
        go(E_IB | E_ILL, 2, 8'h1A, 8'h04);
        srw(16'h8000);
        IRQ_LEVEL = 3'h3;
        go(E_IB, 2, 8'h09, 8'h1B);
        chk("status", PROCESSOR_STATUS_WORD, 16'h2300);
        chk("saved", SAVED_STATUS_WORD, 16'h2000);
        srw(16'h8000);
        TRAP_NUM = 4'hF;
        go(E_IB | E_TRP, 2, 8'h09, 8'h2F);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge MCLK);
        error_cnt++;
        final_report();
    end
endmodule : exception_vector_priority_unit_tb_top

`default_nettype wire

// ==== sim/vec_partner.sv ====
/*
 * Model of interrupting peripherals and vector table memory.
 * Assumes level requests held until their done pulse.
 */
`default_nettype none

module vec_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] req,
    input wire logic [3:0] lat,
    input wire logic avec,
    input wire logic berr,
    input wire logic [7:0] vbyte,
    output logic [2:0] done,
    output logic bus_err,
    output logic avec_n,
    output logic [15:0] data
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Answers each request after lat cycles, once.
    // ----------------------------------------------------------------
    logic [3:0] cnt [3];
    logic [2:0] hold;
    logic [15:0] last = 16'h0;
    initial done = 3'h0;
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            done[i] <= 1'h0;
            if (rst || !req[i]) begin
                cnt[i] <= 4'h0;
                hold[i] <= 1'h0;
            end else if (!hold[i] && cnt[i] == lat) begin
                done[i] <= 1'h1;
                hold[i] <= 1'h1;
            end else if (!hold[i]) begin
                cnt[i] <= cnt[i] + 4'h1;
            end
        end
        if (done[0]) begin
            last <= data;
        end
    end
    assign data = done[0] ? {8'hC3, vbyte} : ~last;
    assign avec_n = !(done[0] && avec);
    assign bus_err = done[0] && berr;
endmodule : vec_partner

`default_nettype wire
